// *** common/rtc_alarm_map.svh ***
// register offsets, field positions and the alarm time reset value of the alarm block
// assumes a 32-bit APB slave with word-aligned registers
`ifndef RTC_ALARM_MAP_SVH
`define RTC_ALARM_MAP_SVH

`define ALM_OFF_TIME 12'h000
`define ALM_OFF_CLOCK 12'h004
`define ALM_OFF_STATUS 12'h008
`define ALM_OFF_MASK 12'h00C
`define ALM_HOUR_TENS_LSB 28
`define ALM_HOUR_UNITS_LSB 24
`define ALM_MINUTE_TENS_LSB 20
`define ALM_MINUTE_UNITS_LSB 16
`define ALM_SECOND_TENS_LSB 12
`define ALM_SECOND_UNITS_LSB 8
`define ALM_TIME_RESET 24'h000000
`define ALM_STAT_MATCH 0

`endif

// *** common/rtc_alarm_pkg.sv ***
// types of the alarm time block
// assumes the map header for offsets
package rtc_alarm_pkg;
    typedef struct packed {
        logic [3:0] hourTens;
        logic [3:0] hourUnits;
        logic [3:0] minuteTens;
        logic [3:0] minuteUnits;
        logic [3:0] secondTens;
        logic [3:0] secondUnits;
    } bcd_time_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage

// *** dv/tb_rtc_alarm_time.sv ***
// self-checking bench of the alarm time register block
// assumes apb slave answering in one access cycle, same clock for clockTime
`timescale 1ns/1ps
module tb_rtc_alarm_time;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic alarmEvent;
    logic irq;
    rtc_alarm_pkg::bcd_time_t clockTime = 24'h000000;
    int err_total = 0;
    int checked = 0;
    logic [31:0] rd;
    logic er;

    always #25 clk_sys = ~clk_sys;

    rtc_alarm_time dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clockTime(clockTime), .alarmEvent(alarmEvent), .irq(irq));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task test_done;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_fields;
        logic [31:0] v [2];
        v = '{32'h235958A5, 32'h109407FF};
        foreach (v[i]) begin
            apb(1'b1, 12'h000, v[i]);
            apb(1'b0, 12'h000, 32'h0);
            chk("time", {v[i][31:8], 8'h00}, rd);
            chk("time err", 32'h0, {31'h0, er});
        end
    endtask

    task t_unmapped;
        apb(1'b0, 12'h0F0, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'b0, 12'h000, 32'h0);
        chk("time kept", 32'h10940700, rd);
    endtask

    task t_regs;
        clockTime <= 24'h010203;
        apb(1'b1, 12'h004, 32'hFFFFFF00);
        apb(1'b0, 12'h004, 32'h0);
        chk("clock read", 32'h01020300, rd);
        apb(1'b1, 12'h0F0, 32'hFFFFFFFF);
        chk("unmapped wr err", 32'h1, {31'h0, er});
        apb(1'b0, 12'h000, 32'h0);
        chk("time after bad wr", 32'h10940700, rd);
        apb(1'b1, 12'h00C, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk("mask off", 32'h0, rd);
    endtask

    task t_alarm;
        int c;
        c = 0;
        apb(1'b1, 12'h00C, 32'h1);
        apb(1'b1, 12'h000, 32'h12345600);
        @(posedge clk_sys);
        clockTime <= 24'h123456;
        repeat (6) begin
            @(posedge clk_sys);
            c += (alarmEvent === 1'b1);
        end
        chk("event pulses", 32'h1, c);
        chk("irq set", 32'h1, {31'h0, irq});
        apb(1'b0, 12'h008, 32'h0);
        chk("status", 32'h1, rd & 32'h1);
        apb(1'b1, 12'h008, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk("irq clear", 32'h0, {31'h0, irq});
        apb(1'b1, 12'h00C, 32'h0);
        clockTime <= 24'h123457;
        @(posedge clk_sys);
        clockTime <= 24'h123456;
        repeat (3) @(posedge clk_sys);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b0, 12'h008, 32'h0);
        chk("status masked", 32'h1, rd & 32'h1);
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("time reset", 32'h0, rd);
        t_fields();
        t_unmapped();
        t_regs();
        t_alarm();
        test_done();
    end
endmodule

// *** hw/rtc_alarm_time.sv ***
// alarm time value register with bcd compare and interrupt
// assumes one clock, synchronous reset, running time from same clock
`timescale 1ns/1ps
`include "rtc_alarm_map.svh"

// Functional notes
// - hour tens digit in bits 31:28
// - hour units digit in bits 27:24
// - minute tens digit in bits 23:20
// - minute units digit in bits 19:16
// - second tens digit in bits 15:12
// - second units digit in bits 11:8
// - low byte unimplemented, reads zero
module rtc_alarm_time (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // running clock time
    input wire rtc_alarm_pkg::bcd_time_t clockTime,
    // alarm outputs
    output logic alarmEvent,
    output logic irq
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    rtc_alarm_pkg::bcd_time_t alarmTime;
    rtc_alarm_pkg::bcd_time_t next_alarmTime;
    logic statusMatch;
    logic next_statusMatch;
    logic maskMatch;
    logic next_maskMatch;
    logic matchPrev;
    logic next_matchPrev;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_alarmEvent;
    logic next_irq;
    logic access;
    logic wrEn;
    logic match;
    logic matchRise;
    logic mapped;
    logic [5:0] digitEq;

    assign access = psel && penable && pready;
    assign wrEn = access && pwrite;

    // ------------------------------------------------------------
    // compare
    // ------------------------------------------------------------
    rtc_alarm_digit_eq #(
        .WIDTH(4)
    ) hourTensEq_u (
        .stored(alarmTime.hourTens),
        .running(clockTime.hourTens),
        .equal(digitEq[5])
    );

    rtc_alarm_digit_eq #(
        .WIDTH(4)
    ) hourUnitsEq_u (
        .stored(alarmTime.hourUnits),
        .running(clockTime.hourUnits),
        .equal(digitEq[4])
    );

    rtc_alarm_digit_eq #(
        .WIDTH(4)
    ) minuteTensEq_u (
        .stored(alarmTime.minuteTens),
        .running(clockTime.minuteTens),
        .equal(digitEq[3])
    );

    rtc_alarm_digit_eq #(
        .WIDTH(4)
    ) minuteUnitsEq_u (
        .stored(alarmTime.minuteUnits),
        .running(clockTime.minuteUnits),
        .equal(digitEq[2])
    );

    rtc_alarm_digit_eq #(
        .WIDTH(4)
    ) secondTensEq_u (
        .stored(alarmTime.secondTens),
        .running(clockTime.secondTens),
        .equal(digitEq[1])
    );

    rtc_alarm_digit_eq #(
        .WIDTH(4)
    ) secondUnitsEq_u (
        .stored(alarmTime.secondUnits),
        .running(clockTime.secondUnits),
        .equal(digitEq[0])
    );

    // all six digits must agree
    assign match = &digitEq;
    assign matchRise = match && !matchPrev;

    always_comb begin
        next_alarmTime = alarmTime;
        next_maskMatch = maskMatch;
        next_statusMatch = statusMatch;
        next_matchPrev = match;
        if (wrEn && paddr == `ALM_OFF_TIME) begin
            next_alarmTime.hourTens = pwdata[`ALM_HOUR_TENS_LSB +: 4];
            next_alarmTime.hourUnits = pwdata[`ALM_HOUR_UNITS_LSB +: 4];
            next_alarmTime.minuteTens = pwdata[`ALM_MINUTE_TENS_LSB +: 4];
            next_alarmTime.minuteUnits = pwdata[`ALM_MINUTE_UNITS_LSB +: 4];
            next_alarmTime.secondTens = pwdata[`ALM_SECOND_TENS_LSB +: 4];
            next_alarmTime.secondUnits = pwdata[`ALM_SECOND_UNITS_LSB +: 4];
        end
        if (wrEn && paddr == `ALM_OFF_MASK) begin
            next_maskMatch = pwdata[`ALM_STAT_MATCH];
        end
        if (wrEn && paddr == `ALM_OFF_STATUS && pwdata[`ALM_STAT_MATCH]) begin
            next_statusMatch = 1'b0;
        end
        // set wins over clear
        if (matchRise) begin
            next_statusMatch = 1'b1;
        end
    end

    always_comb begin
        mapped = (paddr == `ALM_OFF_TIME) || (paddr == `ALM_OFF_CLOCK) ||
            (paddr == `ALM_OFF_STATUS) || (paddr == `ALM_OFF_MASK);
        next_pready = psel && !penable;
        next_pslverr = psel && !penable && !mapped;
        next_prdata = 32'h00000000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `ALM_OFF_TIME: next_prdata = {alarmTime, 8'h00};
                `ALM_OFF_CLOCK: next_prdata = {clockTime, 8'h00};
                `ALM_OFF_STATUS: next_prdata = {31'h00000000, statusMatch};
                `ALM_OFF_MASK: next_prdata = {31'h00000000, maskMatch};
                default: next_prdata = 32'h00000000;
            endcase
        end
        next_alarmEvent = matchRise;
        next_irq = next_statusMatch && next_maskMatch;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            alarmTime <= `ALM_TIME_RESET;
            statusMatch <= 1'b0;
            maskMatch <= 1'b0;
            matchPrev <= 1'b1;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            alarmEvent <= 1'b0;
            irq <= 1'b0;
        end else begin
            alarmTime <= next_alarmTime;
            statusMatch <= next_statusMatch;
            maskMatch <= next_maskMatch;
            matchPrev <= next_matchPrev;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            alarmEvent <= next_alarmEvent;
            irq <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_timeWrite;
        psel && penable && pready && pwrite && paddr == `ALM_OFF_TIME;
    endsequence

    // event pulse and sticky status land on the same edge
    sequence s_eventSeen;
        alarmEvent && statusMatch;
    endsequence

    a_hour_tens_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_timeWrite |=> alarmTime.hourTens == $past(pwdata[31:28]))
        else $error("hour tens not stored");
    a_hour_units_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_timeWrite |=> alarmTime.hourUnits == $past(pwdata[27:24]))
        else $error("hour units not stored");
    a_minute_tens_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_timeWrite |=> alarmTime.minuteTens == $past(pwdata[23:20]))
        else $error("minute tens not stored");
    a_minute_units_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_timeWrite |=> alarmTime.minuteUnits == $past(pwdata[19:16]))
        else $error("minute units not stored");
    a_second_tens_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_timeWrite |=> alarmTime.secondTens == $past(pwdata[15:12]))
        else $error("second tens not stored");
    a_second_units_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_timeWrite |=> alarmTime.secondUnits == $past(pwdata[11:8]))
        else $error("second units not stored");
    a_low_byte_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (psel && !penable && !pwrite && paddr == `ALM_OFF_TIME) |=> prdata[7:0] == 8'h00 && pready)
        else $error("low byte not zero");
    a_alarm_event_fire: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (clockTime == alarmTime && !$past(clockTime == alarmTime)) |=> s_eventSeen)
        else $error("alarm event missed");
    a_irq_gated: assert property (@(posedge clk_sys) disable iff (sys_rst)
        irq == (statusMatch && maskMatch))
        else $error("irq differs from status and mask");

    a_event_one_cycle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        alarmEvent |=> !alarmEvent)
        else $error("alarm event longer than one cycle");
    a_event_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
        alarmEvent |-> $past(clockTime == alarmTime))
        else $error("alarm event without match");

    a_status_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (psel && penable && pready && pwrite && paddr == `ALM_OFF_STATUS && pwdata[`ALM_STAT_MATCH]
        && !matchRise) |=> !statusMatch)
        else $error("status not cleared");
    a_status_set_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (psel && penable && pready && pwrite && paddr == `ALM_OFF_STATUS && matchRise) |=> statusMatch)
        else $error("status clear beat the set");
    a_mask_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (psel && penable && pready && pwrite && paddr == `ALM_OFF_MASK)
        |=> maskMatch == $past(pwdata[`ALM_STAT_MATCH]))
        else $error("mask not stored");

    a_ready_after_setup: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (psel && !penable) |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pready |=> !pready)
        else $error("ready longer than one cycle");
    a_error_unmapped: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (psel && !penable && !mapped) |=> pslverr && pready)
        else $error("unmapped access without error");
    a_error_with_ready: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pslverr |-> pready)
        else $error("error outside access cycle");
    a_read_idle_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !pready |-> prdata == 32'h00000000)
        else $error("read data outside access cycle");

    a_time_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (psel && !penable && !pwrite && paddr == `ALM_OFF_TIME) |=> prdata[31:8] == $past(alarmTime))
        else $error("time readback wrong");
    a_clock_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (psel && !penable && !pwrite && paddr == `ALM_OFF_CLOCK) |=> prdata == {$past(clockTime), 8'h00})
        else $error("clock readback wrong");
    a_clock_write_ignored: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (psel && penable && pready && pwrite && paddr == `ALM_OFF_CLOCK) |=> alarmTime == $past(alarmTime))
        else $error("clock write changed alarm time");
    a_unmapped_ignored: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (psel && penable && pready && pwrite && !mapped)
        |=> alarmTime == $past(alarmTime) && maskMatch == $past(maskMatch))
        else $error("unmapped write changed state");
endmodule

// ------------------------------------------------------------
// one bcd digit compare
// ------------------------------------------------------------
module rtc_alarm_digit_eq #(
    parameter int WIDTH = 4
) (
    // digits to compare
    input wire logic [WIDTH-1:0] stored,
    input wire logic [WIDTH-1:0] running,
    // result
    output logic equal
);
    always_comb begin
        equal = (stored == running);
    end
endmodule
